// ### dv/clk_ctl_assertions.sv
`timescale 1ns/10ps
// Port-level checks of the clock controller
module clk_ctl_chk
  import clk_ctl_pkg::*;
#(
  parameter int STAB_CYC_0_P = STAB_CYC_0,
  parameter int STAB_CYC_1_P = STAB_CYC_1,
  parameter int STAB_CYC_2_P = STAB_CYC_2,
  parameter int STAB_CYC_3_P = STAB_CYC_3
) (
  // Clock, reset and inputs
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  input wire clk_ctl_pkg::cfg_t     cfg,
  input wire clk_ctl_pkg::reg_req_t reg_req,
  // Outputs
  input wire logic [7:0]            reg_rdata,
  input wire logic                  periph_tick,
  input wire logic                  cpu_tick,
  input wire logic                  instr_tick,
  input wire logic                  sys_clk_run,
  input wire logic                  stab_busy,
  input wire logic                  low_speed_osc_en,
  input wire logic                  watchdog_src_forced,
  input wire clk_ctl_pkg::pin_mode_t pin_mode
);
  int   busy_len;
  logic res, ext, hs;

  // Wait length so far; the count is judged when busy falls
  always_ff @(posedge sys_clk)
  begin
    busy_len <= (!rst_b || !stab_busy) ? 0 : busy_len + 1;
  end

  // Source decode; code 3 counts as internal
  assign res = cfg.clk_src == SRC_RESONATOR;
  assign ext = cfg.clk_src == SRC_EXT_CLK;
  assign hs  = !res && !ext;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_cpu_per; cpu_tick |-> periph_tick; endproperty
  a_cpu_per: assert property (p_cpu_per)
    else $error("cpu tick off a periph tick");
  property p_instr; instr_tick |-> cpu_tick; endproperty
  a_instr: assert property (p_instr)
    else $error("instr tick off a cpu tick");
  property p_ls_kept; !cfg.ls_stoppable |-> low_speed_osc_en; endproperty
  a_ls_kept: assert property (p_ls_kept)
    else $error("low-speed osc stopped while locked");
  property p_wd_src; $past(rst_b) && $past(rst_b, 2) |-> watchdog_src_forced == !cfg.ls_stoppable;
  endproperty
  a_wd_src: assert property (p_wd_src)
    else $error("watchdog source force wrong");
  property p_no_wait; !res |-> !stab_busy; endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("wait without resonator");
  property p_wait_len;
    $fell(stab_busy) |-> busy_len inside {STAB_CYC_0_P, STAB_CYC_1_P, STAB_CYC_2_P, STAB_CYC_3_P};
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("wait length off table");
  property p_wait_run; $fell(stab_busy) |-> ##[0:1] sys_clk_run; endproperty
  a_wait_run: assert property (p_wait_run)
    else $error("clock not back after wait");
  property p_pins; $past(rst_b) && $past(rst_b, 2) |-> pin_mode == {hs, !res, ext, res}; endproperty
  a_pins: assert property (p_pins)
    else $error("oscillator pin use wrong");
  property p_ls_bits; $past(reg_req.addr) == LS_MODE_ADDR |-> reg_rdata[7:1] == 7'h00; endproperty
  a_ls_bits: assert property (p_ls_bits)
    else $error("mode register upper bits set");
endmodule

// ### dv/osc_model.sv
`timescale 1ns/10ps
// Oscillator: dead in reset and STOP, swings DLY cycles after wake
module osc_model #(
  parameter int DLY = 6
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Standby traffic
  input  wire logic stop_req,
  input  wire logic sys_clk_run,
  input  wire logic wake_in,
  // Oscillator status
  output logic      osc_started_in
);
  logic stopped;
  int   cnt;

  // Start-up delay restarts on each stop, so an early count shows up
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || (stop_req && sys_clk_run))
    begin
      stopped <= rst_b;
      cnt     <= 0;
    end
    else if (wake_in || !stopped)
    begin
      stopped <= 1'b0;
      cnt     <= (cnt < DLY) ? cnt + 1 : cnt;
    end
  end
  assign osc_started_in = !stopped && cnt >= DLY;
endmodule

// ### dv/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("Error at %0t: got %0h expected %0h", $time, g, e); \
    end \
  end
// Self-checking bench for the clock controller
module tb;
  import clk_ctl_pkg::*;
  localparam int WAIT[4] = '{4, 8, 16, 32};
  // Design connections
  logic        sys_clk, rst_b, stop_req, wake_in, osc_started_in;
  logic        periph_tick, cpu_tick, instr_tick, sys_clk_run, stab_busy;
  logic        low_speed_osc_en, watchdog_src_forced, watchdog_run, interval_timer_h_run;
  logic [7:0]  reg_rdata;
  logic [1:0]  periph_div_sel;
  logic [2:0]  cpu_div_sel;
  cfg_t        cfg;
  reg_req_t    reg_req;
  pin_mode_t   pin_mode;
  int          failures, checked, np, nc, ni, n;
  // Divider codes, then periph and cpu ticks in 128 cycles; last two are refused codes
  logic [20:0] rows [8] = '{{2'h0, 3'h0, 8'h80, 8'h80}, {2'h1, 3'h1, 8'h40, 8'h20},
                            {2'h2, 3'h2, 8'h20, 8'h08}, {2'h0, 3'h4, 8'h80, 8'h08},
                            {2'h2, 3'h4, 8'h20, 8'h02}, {2'h1, 3'h3, 8'h40, 8'h08},
                            {2'h3, 3'h3, 8'h40, 8'h08}, {2'h1, 3'h7, 8'h40, 8'h08}};

  clock_source_and_prescaler_control #(
    .STAB_CYC_0_P(WAIT[0]), .STAB_CYC_1_P(WAIT[1]),
    .STAB_CYC_2_P(WAIT[2]), .STAB_CYC_3_P(WAIT[3])
  ) clock_source_and_prescaler_control_i (.*);
  osc_model osc_model_i (.*);

  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // The configuration byte only changes under reset
  task automatic boot(input logic [1:0] s, input logic st, input logic [1:0] b);
    rst_b = 1'b0;
    cfg   = '{s, st, b};
    cyc(10);
    rst_b = 1'b1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_req = '{a, 1'b1, 1'b0, 3'h0, 1'b0, d};
    cyc(1);
    reg_req.wr = 1'b0;
    cyc(1);
  endtask
  task automatic bw(input logic [15:0] a, input logic [2:0] i, input logic v);
    reg_req = '{a, 1'b0, 1'b1, i, v, 8'h00};
    cyc(1);
    reg_req.bit_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_req.addr = a;
    cyc(2);
    `CHK(reg_rdata, e)
  endtask
  // Counts wait cycles until the clocks return, bounded
  task automatic wait_run(output int len);
    len = 0;
    for (int i = 0; i < 300 && !sys_clk_run; i++)
    begin
      if (stab_busy && len == 0) `CHK(osc_started_in, 1'b1)
      len += stab_busy;
      cyc(1);
    end
    `CHK(sys_clk_run, 1'b1)
  endtask
  // Stop, check standby consumers, wake
  task automatic nap(output int len);
    stop_req = 1'b1;
    cyc(1);
    stop_req = 1'b0;
    cyc(3);
    `CHK({sys_clk_run, cpu_tick}, 2'h0)
    `CHK(watchdog_run, !cfg.ls_stoppable)
    `CHK(interval_timer_h_run, 1'b1)
    wake_in = 1'b1;
    cyc(3);
    wake_in = 1'b0;
    wait_run(len);
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, well beyond the expected run
  initial
  begin
    cyc(8000);
    $display("Error at %0t: timeout", $time);
    failures++;
    results();
  end

  initial
  begin
    failures = 0;
    checked  = 0;
    stop_req = 1'b0;
    wake_in  = 1'b0;
    reg_req  = '0;
    {periph_div_sel, cpu_div_sel} = 5'h00;
    boot(SRC_EXT_CLK, 1'b1, 2'h0);
    cyc(2);
    `CHK(low_speed_osc_en, 1'b1)
    rd(LS_MODE_ADDR, 8'h00);
    rd(16'h0000, 8'h00);
    $display("reset test done");
    // Divider table
    foreach (rows[i])
    begin
      {periph_div_sel, cpu_div_sel} = rows[i][20:16];
      cyc(70);
      {np, nc, ni} = '0;
      repeat (128)
      begin
        cyc(1);
        np += periph_tick;
        nc += cpu_tick;
        ni += instr_tick;
      end
      `CHK(np, rows[i][15:8])
      `CHK(nc, rows[i][7:0])
      `CHK(ni, rows[i][7:1])
    end
    $display("divider test done");
    // Stop bit by byte and by bit, then reset in mid-run
    wr(LS_MODE_ADDR, 8'hFF);
    rd(LS_MODE_ADDR, 8'h01);
    `CHK(low_speed_osc_en, 1'b0)
    bw(LS_MODE_ADDR, 3'h0, 1'b0);
    rd(LS_MODE_ADDR, 8'h00);
    nap(n);
    `CHK(n, 0)
    bw(LS_MODE_ADDR, 3'h0, 1'b1);
    boot(SRC_EXT_CLK, 1'b0, 2'h0);
    cyc(2);
    rd(LS_MODE_ADDR, 8'h00);
    wr(LS_MODE_ADDR, 8'h01);
    cyc(2);
    `CHK({low_speed_osc_en, watchdog_src_forced}, 2'h3)
    nap(n);
    $display("low-speed test done");
    // Resonator: boot wait from the configuration byte, then each select code
    boot(SRC_RESONATOR, 1'b1, 2'h1);
    wait_run(n);
    `CHK(n, WAIT[1])
    for (int k = 0; k < 4; k++)
    begin
      wr(STAB_SEL_ADDR, 8'(k));
      bw(STAB_SEL_ADDR, 3'h1, !k[1]);
      rd(STAB_SEL_ADDR, 8'(k));
      nap(n);
      `CHK(n, WAIT[k])
    end
    $display("stabilization test done");
    results();
  end
endmodule

bind clock_source_and_prescaler_control clk_ctl_chk #(
  .STAB_CYC_0_P(STAB_CYC_0_P), .STAB_CYC_1_P(STAB_CYC_1_P),
  .STAB_CYC_2_P(STAB_CYC_2_P), .STAB_CYC_3_P(STAB_CYC_3_P)
) clk_ctl_chk_i (.*);

// ### inc/clk_ctl_pkg.sv
package clk_ctl_pkg;

  // Register offsets on the memory-manipulation port
  localparam logic [15:0] LS_MODE_ADDR   = 16'hFF58;
  localparam logic [15:0] STAB_SEL_ADDR  = 16'hFFF4;

  // Field positions and reset values
  localparam int          LS_STOP_BIT    = 0;
  localparam logic [7:0]  LS_MODE_RST    = 8'h00;
  localparam logic [1:0]  STAB_SEL_RST   = 2'h3;
  localparam logic [1:0]  PDIV_RST       = 2'h0;
  localparam logic [2:0]  CDIV_RST       = 3'h0;

  // Divider codes: peripheral 0..2, cpu 0..4
  localparam logic [1:0]  PDIV_MAX       = 2'h2;
  localparam logic [2:0]  CDIV_MAX       = 3'h4;

  // System clock source codes from the configuration byte
  localparam logic [1:0]  SRC_HS_INT     = 2'h0;
  localparam logic [1:0]  SRC_RESONATOR  = 2'h1;
  localparam logic [1:0]  SRC_EXT_CLK    = 2'h2;

  // Stabilization waits in system clock cycles
  localparam int          STAB_CYC_0     = 1024;
  localparam int          STAB_CYC_1     = 4096;
  localparam int          STAB_CYC_2     = 32768;
  localparam int          STAB_CYC_3     = 131072;

  // Cycles per fastest instruction
  localparam logic [1:0]  INSTR_CPU_CLKS = 2'h2;

  typedef enum logic [2:0] {
    ST_BOOT_OSC,
    ST_BOOT_STAB,
    ST_RUN,
    ST_STOP,
    ST_OSC_WAIT,
    ST_STAB
  } fsm_t;

  // Configuration byte as seen by the block
  typedef struct packed {
    logic [1:0] clk_src;
    logic       ls_stoppable;
    logic [1:0] boot_stab;
  } cfg_t;

  // Register access strobes from the CPU core
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        bit_wr;
    logic [2:0]  bit_idx;
    logic        bit_val;
    logic [7:0]  wdata;
  } reg_req_t;

  // Oscillator pin usage
  typedef struct packed {
    logic osc_in_is_port;
    logic osc_out_is_port;
    logic ext_clk_on_in;
    logic resonator_on;
  } pin_mode_t;

endpackage

// ### logic/clock_source_and_prescaler_control.sv
`timescale 1ns/10ps

module clock_source_and_prescaler_control #(
  parameter int STAB_CYC_0_P = clk_ctl_pkg::STAB_CYC_0,
  parameter int STAB_CYC_1_P = clk_ctl_pkg::STAB_CYC_1,
  parameter int STAB_CYC_2_P = clk_ctl_pkg::STAB_CYC_2,
  parameter int STAB_CYC_3_P = clk_ctl_pkg::STAB_CYC_3
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // Configuration byte
  input  wire clk_ctl_pkg::cfg_t      cfg,
  // Register port
  input  wire clk_ctl_pkg::reg_req_t  reg_req,
  output logic [7:0]                  reg_rdata,
  // Divider settings from the divider registers
  input  wire logic [1:0]             periph_div_sel,
  input  wire logic [2:0]             cpu_div_sel,
  // Standby control and wake events
  input  wire logic                   stop_req,
  input  wire logic                   wake_in,
  input  wire logic                   osc_started_in,
  // Clock enables and sequencing status
  output logic                        periph_tick,
  output logic                        cpu_tick,
  output logic                        instr_tick,
  output logic                        sys_clk_run,
  output logic                        stab_busy,
  // Low-speed oscillator and its consumers
  output logic                        low_speed_osc_en,
  output logic                        watchdog_src_forced,
  output logic                        watchdog_run,
  output logic                        interval_timer_h_run,
  // Oscillator pins
  output clk_ctl_pkg::pin_mode_t      pin_mode
);
  import clk_ctl_pkg::*;

  typedef struct packed {
    // Sequencer
    fsm_t       state;
    // Divider counters and the ratios in force
    logic [1:0] pdiv_cnt;
    logic [3:0] cdiv_cnt;
    logic [1:0] pdiv_act;
    logic [2:0] cdiv_act;
    // Clock enable pulses
    logic       periph_tick;
    logic       cpu_tick;
    logic [1:0] instr_cnt;
    logic       instr_tick;
    // Software-visible register bits
    logic       ls_stop;
    logic [1:0] stab_sel;
    // Stabilization wait, counted down
    logic [17:0] stab_cnt;
    // Registered read data
    logic [7:0] rdata;
    // Low-speed oscillator and its consumers
    logic       ls_en;
    logic       wd_forced;
    logic       wd_run;
    logic       tm_run;
    // Sequencing status
    logic       clk_run;
    logic       busy;
    // Oscillator pin usage
    pin_mode_t  pins;
    // Two-flop synchronisers for the pin inputs
    logic       wake_s1;
    logic       wake_s2;
    logic       osc_s1;
    logic       osc_s2;
  } st_t;

  st_t st_reg;
  st_t st_next;

  // Wait length for a select code
  // Lengths are parameters so that a bench can shorten them
  function automatic logic [17:0] stab_len(input logic [1:0] code);
    logic [17:0] len;
    len = 18'(STAB_CYC_0_P);
    unique case (code)
      2'h0: len = 18'(STAB_CYC_0_P);
      2'h1: len = 18'(STAB_CYC_1_P);
      2'h2: len = 18'(STAB_CYC_2_P);
      2'h3: len = 18'(STAB_CYC_3_P);
    endcase
    return len;
  endfunction

  // Peripheral divider period minus one
  function automatic logic [1:0] pdiv_lim(input logic [1:0] code);
    logic [1:0] lim;
    lim = 2'h0;
    unique case (code)
      2'h0: lim = 2'h0;
      2'h1: lim = 2'h1;
      2'h2: lim = 2'h3;
      // Prohibited code; the caller never loads it
      default: lim = 2'h0;
    endcase
    return lim;
  endfunction

  // Cpu divider period minus one
  function automatic logic [3:0] cdiv_lim(input logic [2:0] code);
    logic [3:0] lim;
    lim = 4'h0;
    unique case (code)
      3'h0: lim = 4'h0;
      3'h1: lim = 4'h1;
      3'h2: lim = 4'h3;
      3'h3: lim = 4'h7;
      3'h4: lim = 4'hF;
      // Unused codes; the caller never loads them
      default: lim = 4'h0;
    endcase
    return lim;
  endfunction

  // Next-state logic for the whole block
  always_comb
  begin
    logic resonator;
    logic running;
    logic standby;
    // Decode used all through the process
    resonator = (cfg.clk_src == SRC_RESONATOR);
    running   = (st_reg.state == ST_RUN);
    standby   = !running;
    st_next   = st_reg;

    // Pin inputs pass two flops before use
    st_next.wake_s1 = wake_in;
    st_next.wake_s2 = st_reg.wake_s1;
    st_next.osc_s1  = osc_started_in;
    st_next.osc_s2  = st_reg.osc_s1;

    // Source sequencing around reset and stop
    st_next.busy = 1'b0;
    unique case (st_reg.state)
      ST_BOOT_OSC:
      begin
        // Boot wait comes from the configuration byte, not the select register
        if (!resonator)
          st_next.state = ST_RUN;
        else if (st_reg.osc_s2)
        begin
          st_next.stab_cnt = stab_len(cfg.boot_stab);
          st_next.state    = ST_BOOT_STAB;
          st_next.busy     = 1'b1;
        end
      end
      ST_BOOT_STAB, ST_STAB:
      begin
        st_next.busy = 1'b1;
        // Counter reaches one on the last waited cycle
        if (st_reg.stab_cnt <= 18'h00001)
        begin
          st_next.stab_cnt = 18'h00000;
          st_next.state    = ST_RUN;
          st_next.busy     = 1'b0;
        end
        else
          st_next.stab_cnt = st_reg.stab_cnt - 18'h00001;
      end
      ST_RUN:
      begin
        // A wake seen here is stale and ignored
        if (stop_req)
          st_next.state = ST_STOP;
      end
      ST_STOP:
      begin
        // Stop requests are refused until the clock is back
        if (st_reg.wake_s2)
          st_next.state = resonator ? ST_OSC_WAIT : ST_RUN;
      end
      ST_OSC_WAIT:
      begin
        // Count only once the oscillator is swinging
        if (st_reg.osc_s2)
        begin
          st_next.stab_cnt = stab_len(st_reg.stab_sel);
          st_next.state    = ST_STAB;
          st_next.busy     = 1'b1;
        end
      end
      default:
      begin
        // Unused codes restart the sequence rather than hang
        st_next.state = ST_BOOT_OSC;
      end
    endcase
    // Clock gate opens together with the run state
    st_next.clk_run = (st_next.state == ST_RUN);

    // Peripheral prescaler; new ratio taken only at a period end
    // Counters hold in standby and resume mid-period after wake
    st_next.periph_tick = 1'b0;
    if (running)
    begin
      if (st_reg.pdiv_cnt >= pdiv_lim(st_reg.pdiv_act))
      begin
        st_next.periph_tick = 1'b1;
        st_next.pdiv_cnt    = 2'h0;
        if (periph_div_sel <= PDIV_MAX)
          st_next.pdiv_act = periph_div_sel;
      end
      else
        st_next.pdiv_cnt = st_reg.pdiv_cnt + 2'h1;
    end

    // Cpu divider counts peripheral ticks
    // Only advances on a peripheral tick, so cpu ticks align with it
    st_next.cpu_tick = 1'b0;
    if (running && st_next.periph_tick)
    begin
      if (st_reg.cdiv_cnt >= cdiv_lim(st_reg.cdiv_act))
      begin
        st_next.cpu_tick = 1'b1;
        st_next.cdiv_cnt = 4'h0;
        if (cpu_div_sel <= CDIV_MAX)
          st_next.cdiv_act = cpu_div_sel;
      end
      else
        st_next.cdiv_cnt = st_reg.cdiv_cnt + 4'h1;
    end

    // Fastest instruction slot every two cpu clocks
    // Phase carries across divider changes
    st_next.instr_tick = 1'b0;
    if (st_next.cpu_tick)
    begin
      if (st_reg.instr_cnt >= INSTR_CPU_CLKS - 2'h1)
      begin
        st_next.instr_tick = 1'b1;
        st_next.instr_cnt  = 2'h0;
      end
      else
        st_next.instr_cnt = st_reg.instr_cnt + 2'h1;
    end

    // Register writes; select register ignores bit writes
    // A byte write wins over a bit write in the same cycle
    if (reg_req.wr && reg_req.addr == LS_MODE_ADDR)
      st_next.ls_stop = reg_req.wdata[LS_STOP_BIT];
    else if (reg_req.bit_wr && reg_req.addr == LS_MODE_ADDR
             && reg_req.bit_idx == 3'(LS_STOP_BIT))
      st_next.ls_stop = reg_req.bit_val;
    if (reg_req.wr && reg_req.addr == STAB_SEL_ADDR)
      st_next.stab_sel = reg_req.wdata[1:0];

    // Read data; unused bits and unmapped addresses give zero
    // Registered one cycle behind the address, on every cycle
    unique case (reg_req.addr)
      LS_MODE_ADDR:  st_next.rdata = {7'h00, st_reg.ls_stop};
      STAB_SEL_ADDR: st_next.rdata = {6'h00, st_reg.stab_sel};
      default:       st_next.rdata = 8'h00;
    endcase

    // Low-speed oscillator; the mode bit is only obeyed if allowed
    // The stored bit still reads back when locked; only its effect is masked
    // Watchdog stops in standby only when software may stop the oscillator
    st_next.ls_en     = !(cfg.ls_stoppable && st_reg.ls_stop);
    st_next.wd_forced = !cfg.ls_stoppable;
    st_next.wd_run    = st_next.ls_en && (!cfg.ls_stoppable || !standby);
    st_next.tm_run    = st_next.ls_en;

    // Oscillator pin usage per source
    // Code 3 is unused and behaves as the internal oscillator
    st_next.pins.resonator_on    = resonator;
    st_next.pins.ext_clk_on_in   = (cfg.clk_src == SRC_EXT_CLK);
    st_next.pins.osc_in_is_port  = !resonator
                                   && (cfg.clk_src != SRC_EXT_CLK);
    st_next.pins.osc_out_is_port = !resonator;

    // Synchronous reset; select reset value is a defined choice
    // Placed last so it overrides every field above
    // Stop bit cleared, low-speed oscillator running from the first cycle
    if (!rst_b)
    begin
      st_next          = '0;
      st_next.state    = ST_BOOT_OSC;
      st_next.ls_stop  = LS_MODE_RST[LS_STOP_BIT];
      st_next.stab_sel = STAB_SEL_RST;
      st_next.pdiv_act = PDIV_RST;
      st_next.cdiv_act = CDIV_RST;
      st_next.ls_en    = 1'b1;
      st_next.tm_run   = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    st_reg <= st_next;
  end

  // Read data straight from the state register
  assign reg_rdata            = st_reg.rdata;

  // Clock enables and sequencing status
  assign periph_tick          = st_reg.periph_tick;
  assign cpu_tick             = st_reg.cpu_tick;
  assign instr_tick           = st_reg.instr_tick;
  assign sys_clk_run          = st_reg.clk_run;
  assign stab_busy            = st_reg.busy;

  // Low-speed oscillator and its consumers
  assign low_speed_osc_en     = st_reg.ls_en;
  assign watchdog_src_forced  = st_reg.wd_forced;
  assign watchdog_run         = st_reg.wd_run;
  assign interval_timer_h_run = st_reg.tm_run;

  // Oscillator pin usage
  assign pin_mode             = st_reg.pins;

endmodule
